// ==== src/src_conv_pkg.sv ====
// Purpose: shared constants and types of the rate converter core
// Assumes: one 100 MHz system clock, synchronous active-high reset
// Notes:   offsets, field positions, reset values and counts live here, except the fast mode reset set in the core
package src_conv_pkg;

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0]  CLK_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  CLK_CTRL_RESET  = 8'h00;
    localparam int          SRC_SEL_LSB     = 0;   // two bits: source select
    localparam int          CLK_DIV_LSB     = 2;   // two bits: divide by 1,2,4,8
    localparam int          GD_MUTE_BIT     = 7;   // soft mute in group delay reg

    // --------------------------------------------------------------
    // datapath figures
    // --------------------------------------------------------------
    localparam logic [8:0]  WR_OFFSET_MIN   = 9'h010;        // 16 samples
    localparam int          RAM_DEPTH       = 512;
    localparam int          RAM_AW          = 9;
    localparam logic [6:0]  RATIO_UNITY     = 7'h40;         // 64 = equal rates
    localparam logic [6:0]  RATIO_MIN       = 7'h09;         // deepest decimation
    localparam logic [6:0]  RATIO_HYST      = 7'h02;         // two output periods
    localparam logic [25:0] ROM_STEP_UNITY  = 26'h0100000;   // 2^20 per tap
    localparam int          ROM_STEP_SHIFT  = 14;            // ratio/64 * 2^20
    localparam logic [6:0]  MUTE_GAIN_FULL  = 7'h40;
    localparam int          OUT_LSB         = 21;            // accumulator tap-off

    // --------------------------------------------------------------
    // servo loop figures
    // --------------------------------------------------------------
    localparam int          FAST_SHIFT      = 1;
    localparam int          SLOW_SHIFT      = 4;
    localparam logic [16:0] SETTLE_TOL      = 17'h00002;
    localparam logic [16:0] CHANGE_TOL      = 17'h00020;
    localparam logic [3:0]  SETTLE_RUN      = 4'h8;

    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } sample_pair_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_READ  = 3'b011,
        ST_MAC_L = 3'b010,
        ST_MAC_R = 3'b110
    } conv_state_type;

    typedef struct packed {
        logic                   en;
        logic [RAM_AW-1:0]      addr;
        sample_pair_type        data;
    } ram_write_type;

endpackage

// ==== src/sample_store.sv ====
// Purpose: 512-word stereo input sample memory
// Assumes: one write and one read per clock
// Notes:   read data comes out of a register, one cycle after the address
`timescale 1ns/1ns
module sample_store
    import src_conv_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire ram_write_type     i_wr,
    input  wire logic [RAM_AW-1:0] i_rd_addr,
    output sample_pair_type        o_rd_data
);

    sample_pair_type mem [RAM_DEPTH];

    // write port and registered read port
    always_ff @(posedge i_clk_sys)
    begin
        if (i_wr.en)
        begin
            mem[i_wr.addr] <= i_wr.data;
        end
        o_rd_data <= mem[i_rd_addr];
    end

endmodule

// ==== src/src_conv_core.sv ====
// Purpose: servo loop, rate ratio and polyphase convolution of the converter
// Assumes: input strobes are synchronous one-cycle pulses on i_clk_sys
// Notes:   one multiplier serves both channels, left then right per tap
// Operation
// - servo enters fast mode at startup or rate change, slow once settled
// - settling mute flag is high throughout fast mode
// - group delay bit 7 soft-mutes the converter output
// - flag can raise an interrupt on the fast to slow change
// - 64 taps when output rate not lower, else 64 times in/out ratio
// - each output period loads RAM and ROM start pointers from the servo
// - RAM address falls by one per tap
// - ROM pointer steps 2^20, or out/in ratio times 2^20 when decimating
// - convolution ends when the ROM pointer wraps
// - both channels convolved each period through one shared MAC
// - ratio from comparing output and input rate counters, scales coefficients
// - while decimating, ratio replaced only if it moved more than two periods
// - clock source of four and its divider set in register 0x00
// - FIFO write offset is 16 plus group delay bits 6 to 0
// - sample store holds 512 words per channel
// - when decimating, input samples are scaled by out/in ratio
`timescale 1ns/1ns
module src_conv_core
    import src_conv_pkg::*;
(
    input  wire logic            i_clk_sys,
    input  wire logic            i_reset,
    input  wire logic            i_reg_wr,
    input  wire logic [7:0]      i_reg_addr,
    input  wire logic [7:0]      i_reg_wdata,
    output logic [7:0]           o_reg_rdata,
    input  wire logic [3:0]      i_src_tick,
    input  wire logic [7:0]      i_group_delay,
    input  wire logic            i_irq_enable,
    input  wire logic            i_in_valid,
    input  wire sample_pair_type i_in_sample,
    input  wire logic            i_fs_out_tick,
    output logic                 o_mclk_tick,
    output logic                 o_settling_mute_flag,
    output logic                 o_settle_irq,
    output sample_pair_type      o_out_sample,
    output logic                 o_out_valid,
    output logic                 o_conv_busy
);

    // --------------------------------------------------------------
    // state and helpers
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0]         clk_ctrl;
        logic [2:0]         div_cnt;
        logic               mclk_tick;
        logic [15:0]        meas;
        logic [15:0]        est;
        logic               fast;
        logic [3:0]         settle_run;
        logic               irq;
        logic [8:0]         in_cnt;
        logic [6:0]         win_cnt;
        logic [6:0]         out_cnt;
        logic [6:0]         ratio;
        logic               win_end;
        logic [6:0]         mute_gain;
        conv_state_type     st;
        logic [8:0]         ram_addr;
        logic [25:0]        rom_ptr;
        logic [25:0]        rom_step;
        logic signed [39:0] acc_l;
        logic signed [39:0] acc_r;
        sample_pair_type    out;
        logic               out_valid;
        logic               pend;
        logic               busy;
    } core_state_type;

    core_state_type  state_reg;
    core_state_type  state_next;
    ram_write_type   wr;
    sample_pair_type rd_data;

    // coefficient from ROM pointer, shrunk by ratio when decimating
    function automatic logic signed [15:0] coef_of(input logic [25:0] p,
                                                   input logic [6:0]  r);
        logic [14:0] tri_v;
        logic [21:0] sc;
        tri_v = p[25] ? ~p[24:10] : p[24:10];
        sc = (r < RATIO_UNITY) ? 22'(tri_v) * 22'(r) : {1'b0, tri_v, 6'h00};
        return {1'b0, sc[20:6]};
    endfunction

    // input scaling by rate ratio and soft-mute gain
    function automatic logic signed [15:0] scale_in(input logic signed [15:0] s,
                                                    input logic [6:0]  r,
                                                    input logic [6:0]  mg);
        logic [6:0]         g;
        logic signed [23:0] a;
        logic signed [31:0] b;
        g = (r < RATIO_UNITY) ? r : RATIO_UNITY;
        a = s * $signed({1'b0, g});
        b = a * $signed({1'b0, mg});
        return b[27:12];
    endfunction

    sample_store u_store (
        .i_clk_sys (i_clk_sys),
        .i_wr      (wr),
        .i_rd_addr (state_reg.ram_addr),
        .o_rd_data (rd_data)
    );

    // --------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------
    always_comb
    begin
        logic [1:0]         sel;
        logic [2:0]         div_top;
        logic signed [16:0] diff;
        logic [16:0]        mag;
        logic [6:0]         rdiff;
        logic [26:0]        ptr_sum;
        logic signed [15:0] mul_a;
        logic signed [15:0] c;
        logic signed [31:0] prod;
        state_next = state_reg;
        sel = '0;
        div_top = '0;
        mul_a = '0;
        c = '0;
        wr = '0;
        diff = '0;
        mag = '0;
        rdiff = '0;
        ptr_sum = '0;
        prod = '0;

        // register 0x00: source select and divider
        if (i_reg_wr && i_reg_addr == CLK_CTRL_ADDR)
        begin
            state_next.clk_ctrl = i_reg_wdata;
        end

        // master tick: chosen source divided by 1, 2, 4 or 8
        sel = state_reg.clk_ctrl[SRC_SEL_LSB +: 2];
        div_top = 3'((4'h1 << state_reg.clk_ctrl[CLK_DIV_LSB +: 2]) - 4'h1);
        state_next.mclk_tick = 1'b0;
        if (i_src_tick[sel])
        begin
            if (state_reg.div_cnt >= div_top)
            begin
                state_next.div_cnt = 3'h0;
                state_next.mclk_tick = 1'b1;
            end
            else
            begin
                state_next.div_cnt = state_reg.div_cnt + 3'h1;
            end
        end

        // input period measured in master ticks
        if (state_reg.mclk_tick && state_reg.meas != 16'hffff)
        begin
            state_next.meas = state_reg.meas + 16'h0001;
        end

        // servo loop: period estimate, fast or slow tracking
        state_next.irq = 1'b0;
        if (i_in_valid)
        begin
            state_next.meas = 16'h0000;
            diff = $signed({1'b0, state_reg.meas}) - $signed({1'b0, state_reg.est});
            mag = diff[16] ? 17'(-diff) : 17'(diff);
            if (state_reg.fast)
            begin
                state_next.est = 16'(state_reg.est + 16'(diff >>> FAST_SHIFT));
                if (mag <= SETTLE_TOL)
                begin
                    state_next.settle_run = state_reg.settle_run + 4'h1;
                end
                else
                begin
                    state_next.settle_run = 4'h0;
                end
                if (state_next.settle_run >= SETTLE_RUN)
                begin
                    state_next.fast = 1'b0;
                    state_next.settle_run = 4'h0;
                    state_next.irq = i_irq_enable;
                end
            end
            else
            begin
                state_next.est = 16'(state_reg.est + 16'(diff >>> SLOW_SHIFT));
                if (mag > CHANGE_TOL)
                begin
                    state_next.fast = 1'b1;
                end
            end

            // fifo write at counter plus offset, after scaling and mute
            wr.en = 1'b1;
            wr.addr = state_reg.in_cnt + WR_OFFSET_MIN + {2'b00, i_group_delay[6:0]};
            wr.data.left = scale_in(i_in_sample.left, state_reg.ratio,
                                    state_reg.mute_gain);
            wr.data.right = scale_in(i_in_sample.right, state_reg.ratio,
                                     state_reg.mute_gain);
            state_next.in_cnt = state_reg.in_cnt + 9'h001;

            // soft mute ramp, one step per input sample
            if (i_group_delay[GD_MUTE_BIT] && state_reg.mute_gain != 7'h00)
            begin
                state_next.mute_gain = state_reg.mute_gain - 7'h01;
            end
            else if (!i_group_delay[GD_MUTE_BIT] && state_reg.mute_gain < MUTE_GAIN_FULL)
            begin
                state_next.mute_gain = state_reg.mute_gain + 7'h01;
            end
        end

        // rate ratio: output ticks counted over 64 input ticks
        state_next.win_end = 1'b0;
        if (i_fs_out_tick && state_reg.out_cnt != 7'h7f)
        begin
            state_next.out_cnt = state_next.out_cnt + 7'h01;
        end
        if (i_in_valid)
        begin
            state_next.win_cnt = state_reg.win_cnt + 7'h01;
            if (state_reg.win_cnt == RATIO_UNITY - 7'h01)
            begin
                state_next.win_cnt = 7'h00;
                state_next.out_cnt = 7'h00;
                state_next.win_end = 1'b1;
                rdiff = (state_reg.out_cnt > state_reg.ratio)
                      ? state_reg.out_cnt - state_reg.ratio
                      : state_reg.ratio - state_reg.out_cnt;
                if (state_reg.out_cnt >= RATIO_UNITY || rdiff > RATIO_HYST)
                begin
                    state_next.ratio = (state_reg.out_cnt < RATIO_MIN)
                                     ? RATIO_MIN : state_reg.out_cnt;
                end
            end
        end

        // convolution sequencer
        state_next.out_valid = 1'b0;
        if (i_fs_out_tick)
        begin
            state_next.pend = 1'b1;
        end
        mul_a = (state_reg.st == ST_MAC_R) ? rd_data.right : rd_data.left;
        c = coef_of(state_reg.rom_ptr, state_reg.ratio);
        prod = mul_a * c;
        ptr_sum = {1'b0, state_reg.rom_ptr} + {1'b0, state_reg.rom_step};
        case (state_reg.st)
            ST_IDLE:
            begin
                if (state_reg.pend)
                begin
                    state_next.pend = i_fs_out_tick;
                    state_next.st = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                // start pointers from the servo: integer and fraction
                state_next.ram_addr = state_reg.in_cnt - 9'h001;
                state_next.rom_ptr = {6'h00, (state_reg.meas[15:8] != 8'h00)
                                     ? 8'hff : state_reg.meas[7:0], 12'h000};
                state_next.rom_step = (state_reg.ratio < RATIO_UNITY)
                                    ? 26'(state_reg.ratio) << ROM_STEP_SHIFT
                                    : ROM_STEP_UNITY;
                state_next.acc_l = '0;
                state_next.acc_r = '0;
                state_next.st = ST_READ;
            end
            ST_READ:
            begin
                state_next.st = ST_MAC_L;
            end
            ST_MAC_L:
            begin
                state_next.acc_l = state_reg.acc_l + 40'(prod);
                state_next.st = ST_MAC_R;
            end
            ST_MAC_R:
            begin
                state_next.acc_r = state_reg.acc_r + 40'(prod);
                state_next.rom_ptr = ptr_sum[25:0];
                state_next.ram_addr = state_reg.ram_addr - 9'h001;
                if (ptr_sum[26])
                begin
                    state_next.out.left = state_reg.acc_l[OUT_LSB +: 16];
                    state_next.out.right = state_next.acc_r[OUT_LSB +: 16];
                    state_next.out_valid = 1'b1;
                    state_next.st = ST_IDLE;
                end
                else
                begin
                    state_next.st = ST_READ;
                end
            end
            default:
            begin
                state_next.st = ST_IDLE;
            end
        endcase
        // busy flag registered so the output comes from a flip-flop
        state_next.busy = (state_next.st != ST_IDLE);
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state_reg <= '0;
            state_reg.clk_ctrl <= CLK_CTRL_RESET;
            state_reg.fast <= 1'b1;
            state_reg.ratio <= RATIO_UNITY;
            state_reg.mute_gain <= MUTE_GAIN_FULL;
            state_reg.st <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign o_reg_rdata = state_reg.clk_ctrl;
    assign o_mclk_tick = state_reg.mclk_tick;
    assign o_settling_mute_flag = state_reg.fast;
    assign o_settle_irq = state_reg.irq;
    assign o_out_sample = state_reg.out;
    assign o_out_valid = state_reg.out_valid;
    assign o_conv_busy = state_reg.busy;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    chk_fast_after_reset: assert property ($fell(i_reset) |-> o_settling_mute_flag)
        else $error("fast mode not active after reset");
    chk_irq_on_fall: assert property (o_settle_irq |-> $fell(o_settling_mute_flag))
        else $error("interrupt without flag falling");
    chk_irq_enabled: assert property ($fell(o_settling_mute_flag) && $past(i_irq_enable)
        |-> o_settle_irq)
        else $error("enabled interrupt missing on slow mode entry");
    chk_ram_dec_one: assert property (state_reg.st == ST_MAC_R
        |=> state_reg.ram_addr == $past(state_reg.ram_addr) - 9'h001)
        else $error("ram address did not fall by one");
    chk_rom_unity: assert property (state_reg.st == ST_LOAD && state_reg.ratio >= RATIO_UNITY
        |=> state_reg.rom_step == ROM_STEP_UNITY)
        else $error("rom step not 2^20 at unity or upsampling");
    chk_load_then_read: assert property (state_reg.st == ST_LOAD
        |=> state_reg.st == ST_READ && state_reg.rom_ptr[25:20] == 6'h00
            ##1 state_reg.st == ST_MAC_L ##1 state_reg.st == ST_MAC_R)
        else $error("convolution start sequence broken");
    chk_end_on_wrap: assert property (state_reg.st == ST_MAC_R
        && state_reg.rom_ptr > state_next.rom_ptr |=> o_out_valid && !o_conv_busy)
        else $error("convolution did not end on rom wrap");
    chk_mute_ramp: assert property (i_in_valid && i_group_delay[GD_MUTE_BIT]
        && state_reg.mute_gain != 7'h00
        |=> state_reg.mute_gain == $past(state_reg.mute_gain) - 7'h01)
        else $error("soft mute ramp did not step down");
    chk_ratio_hyst: assert property (state_reg.ratio != $past(state_reg.ratio)
        && $past(state_reg.ratio) < RATIO_UNITY && state_reg.ratio < RATIO_UNITY
        |-> state_reg.win_end && (state_reg.ratio > $past(state_reg.ratio) + RATIO_HYST
            || state_reg.ratio + RATIO_HYST < $past(state_reg.ratio)))
        else $error("ratio changed within hysteresis band");

    cov_slow_reached: cover property ($fell(o_settling_mute_flag));
    cov_conv_done: cover property (o_out_valid);
    cov_decimating: cover property (state_reg.st == ST_LOAD && state_reg.ratio < RATIO_UNITY);
    cov_muted: cover property (state_reg.mute_gain == 7'h00);

endmodule

// ==== testbench/audio_stream_model.sv ====
// Purpose: source and sink model that feeds samples and output periods to the core
// Assumes: steady input period set by the bench, mclk ticks counted from the core
// Notes:   sample lines carry the inverse of the last word outside the strobe
`timescale 1ns/1ns
module audio_stream_model
    import src_conv_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic        i_run,
    input  wire logic [15:0] i_in_period,
    input  wire logic        i_mclk_tick,
    output logic             o_in_valid,
    output sample_pair_type  o_in_sample,
    output logic             o_fs_out_tick
);
    logic [15:0]     in_cnt_reg;
    logic [7:0]      mclk_cnt_reg;
    sample_pair_type smp_reg;

    // ------------------------------------------------------------
    // input samples and output period strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        o_in_valid <= 1'b0;
        o_fs_out_tick <= 1'b0;
        if (i_reset || !i_run)
        begin
            in_cnt_reg <= 16'h0000;
            mclk_cnt_reg <= 8'h00;
            smp_reg <= '0;
        end
        else
        begin
            in_cnt_reg <= (in_cnt_reg >= i_in_period - 16'h0001) ? 16'h0000 : in_cnt_reg + 16'h0001;
            if (in_cnt_reg == 16'h0000)
            begin
                o_in_valid <= 1'b1;
                smp_reg.left <= smp_reg.left + 16'sh0123;
                smp_reg.right <= smp_reg.right - 16'sh0321;
            end
            // one output period per 256 master ticks
            if (i_mclk_tick)
            begin
                mclk_cnt_reg <= mclk_cnt_reg + 8'h01;
                o_fs_out_tick <= (mclk_cnt_reg == 8'hff);
            end
        end
    end

    // released data lines show the inverse of the held word
    assign o_in_sample = o_in_valid ? smp_reg : ~smp_reg;
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the rate converter core
// Assumes: register writes are one-cycle strobes, results sampled 1 ns after the edge
// Notes:   output sample values are not compared, the sample store starts unwritten
`timescale 1ns/1ns
module tb_top
    import src_conv_pkg::*;
;
    logic            clk, reset, reg_wr, irq_en, run, in_valid, fs_tick;
    logic            mclk, flag, irq, out_valid, busy;
    logic [7:0]      reg_addr, reg_wdata, rdata, gdelay;
    logic [3:0]      src_tick;
    logic [15:0]     in_period;
    sample_pair_type in_smp, out_smp;
    int              errors, n_tests, cyc, ticks, irqs;

    // ------------------------------------------------------------
    // design, far side model, clock and monitors
    // ------------------------------------------------------------
    src_conv_core dut (.i_clk_sys(clk), .i_reset(reset), .i_reg_wr(reg_wr),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
        .i_src_tick(src_tick), .i_group_delay(gdelay), .i_irq_enable(irq_en),
        .i_in_valid(in_valid), .i_in_sample(in_smp), .i_fs_out_tick(fs_tick),
        .o_mclk_tick(mclk), .o_settling_mute_flag(flag), .o_settle_irq(irq),
        .o_out_sample(out_smp), .o_out_valid(out_valid), .o_conv_busy(busy));
    audio_stream_model model (.i_clk_sys(clk), .i_reset(reset), .i_run(run),
        .i_in_period(in_period), .i_mclk_tick(mclk), .o_in_valid(in_valid),
        .o_in_sample(in_smp), .o_fs_out_tick(fs_tick));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // tick and interrupt tallies, run ceiling
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (mclk === 1'b1) ticks <= ticks + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 90000)
        begin
            errors = errors + 1;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic reg_idle();
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic wait_flag(input logic lvl, input int lim);
        int k;
        k = 0;
        while (flag !== lvl && k < lim)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        check("flag level reached", {31'h0, k < lim}, 32'h1);
    endtask

    // busy cycles of one full conversion, bracketed by two results
    task automatic measure_conv(input int taps);
        int k, n;
        k = 0;
        n = 0;
        while (out_valid !== 1'b1 && k < 2000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        #1;
        while (out_valid !== 1'b1 && k < 4000)
        begin
            if (busy === 1'b1) n++;
            @(posedge clk);
            #1;
            k++;
        end
        check("busy low with result", {31'h0, busy}, 32'h0);
        check("conversion length", {31'h0, n == 1 + 3 * taps || n == 3 * taps - 2}, 32'h1);
    endtask

    task automatic stop_test();
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {errors, n_tests, cyc, ticks, irqs} = '0;
        {reset, reg_wr, irq_en, run} = 4'b1000;
        {reg_addr, reg_wdata, gdelay, src_tick} = '0;
        in_period = 16'h0100;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check("reset outputs", {rdata, flag, irq, out_valid, busy, mclk}, {8'h00, 5'b10000});
        reg_write(CLK_CTRL_ADDR, 8'h05);
        reg_write(8'h01, 8'haa);
        #1;
        check("clock control", {24'h0, rdata}, 32'h05);
        reg_idle();
        #1;
        check("unmapped write", {24'h0, rdata}, 32'h05);
        for (int s = 0; s < 4; s++)
            for (int d = 0; d < 4; d++)
            begin
                reg_write(CLK_CTRL_ADDR, {4'hf, d[1:0], s[1:0]});
                reg_idle();
                #1;
                check("select readback", {24'h0, rdata}, {24'h0, 4'hf, d[1:0], s[1:0]});
                ticks = 0;
                repeat (8)
                begin
                    @(posedge clk);
                    src_tick <= 4'h1 << s;
                    @(posedge clk);
                    src_tick <= ~(4'h1 << s);
                end
                @(posedge clk);
                src_tick <= 4'h0;
                repeat (3) @(posedge clk);
                check("divided ticks", ticks, 8 >> d);
            end
        reg_write(CLK_CTRL_ADDR, 8'h00);
        reg_idle();
        src_tick <= 4'h1;
        irq_en <= 1'b1;
        run <= 1'b1;
        irqs = 0;
        wait_flag(1'b0, 30000);
        check("irq with settle", {31'h0, irq}, 32'h1);
        @(posedge clk);
        #1;
        check("irq one cycle", {31'h0, irq}, 32'h0);
        measure_conv(64);
        in_period <= 16'h0080;
        irq_en <= 1'b0;
        wait_flag(1'b1, 1000);
        gdelay <= 8'h8a;
        repeat (192) @(posedge in_valid);
        gdelay <= 8'h00;
        measure_conv(128);
        wait_flag(1'b0, 30000);
        check("masked irq", irqs, 1);
        stop_test();
    end
endmodule
